// >>> inc/cw_access_pkg.sv
// constants shared by the control word access block
package cw_access_pkg;
  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int SEQ_W = 8;
  localparam int IDX_W = 8;
  localparam logic [SEQ_W-1:0] SEQ_FIRST = 8'h00;
  localparam logic [IDX_W-1:0] IDX_LAST = 8'hFF;
  // ----------------------------------------------------------------
  // build options
  // ----------------------------------------------------------------
  localparam int LAT_MAX = 9;
  localparam int LAT_DEFAULT = 0;
  localparam int LAT_BASE = 1;
  localparam int LAT_CNT_W = 4;
  localparam int FIFO_DEPTH = 32;
  // ----------------------------------------------------------------
  // reset values and address shift amounts
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
  localparam logic [LAT_CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [1:0] ADDR_SHIFT_WORD = 2'h0;
  localparam logic [1:0] ADDR_SHIFT_BYTE = 2'h2;
  // word or byte addressing of the register port
  typedef enum logic {ADDR_WORD, ADDR_BYTE} addr_mode_t;
  // source that won the transmit control word slot
  typedef enum {SRC_NONE, SRC_STD, SRC_OVERRIDE} cw_src_t;
  // total write latency for an extra setting n
  function automatic logic [LAT_CNT_W-1:0] eff_lat(input int n);
    eff_lat = LAT_CNT_W'(LAT_BASE + n);
  endfunction
endpackage

// >>> rtl/cw_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/10ps
module cw_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // honest flags from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  // storage has no reset, pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  chk_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// >>> rtl/cw_access.sv
// aux/direct tx write timing and control word register access
`timescale 1ns/10ps
module cw_access
  import cw_access_pkg::*;
#(
  parameter addr_mode_t ADDR_MODE = ADDR_WORD,
  parameter int EXTRA_LAT = LAT_DEFAULT,
  parameter bit AUX_EN = 1'b0,
  parameter bit DIRECT_EN = 1'b1,
  parameter bit CW_ACCESS_EN = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // frame position from the framer
  input wire logic [SEQ_W-1:0] frame_seq,
  input wire logic [IDX_W-1:0] hf_pos,
  // register port
  input wire logic [IDX_W+1:0] reg_addr,
  input wire logic [WORD_W-1:0] idx_wr,
  input wire logic idx_we,
  input wire logic [WORD_W-1:0] txcw_wr,
  input wire logic txcw_we,
  input wire logic txcw_en,
  // aux tx from user logic
  input wire logic aux_tx_valid,
  input wire logic [WORD_W-1:0] aux_tx_data,
  // direct tx from user logic
  input wire logic dir_tx_valid,
  input wire logic [WORD_W-1:0] dir_tx_data,
  // control word sources of lower priority
  input wire logic std_cw_valid,
  input wire logic [WORD_W-1:0] std_cw_data,
  // received frame stream
  input wire logic [WORD_W-1:0] rx_word,
  // frame out toward the line
  input wire logic tx_ready,
  // outputs
  output logic aux_seq_out,
  output logic dir_tx_ready,
  output logic [WORD_W-1:0] tx_cw_q,
  output logic tx_cw_valid_q,
  output logic [IDX_W-1:0] idx_q,
  output logic [WORD_W-1:0] rx_cw_q,
  output logic [WORD_W-1:0] tx_word_q,
  output logic tx_valid_q
);
  // ----------------------------------------------------------------
  // build-time derived settings
  // ----------------------------------------------------------------
  localparam int LAT_USED = DIRECT_EN ? EXTRA_LAT : LAT_DEFAULT;
  localparam logic [LAT_CNT_W-1:0] LAT_TOTAL = eff_lat(LAT_USED);
  localparam logic [1:0] ASHIFT =
    (ADDR_MODE == ADDR_BYTE) ? ADDR_SHIFT_BYTE : ADDR_SHIFT_WORD;

  // ----------------------------------------------------------------
  // write latency window
  // ----------------------------------------------------------------
  logic [LAT_CNT_W-1:0] lat_cnt_q, lat_cnt_d;
  logic lat_run_q, lat_run_d;
  logic dir_ready_q;
  wire seq_zero = (frame_seq == SEQ_FIRST);
  // the next count is the age of the next cycle, one for the cycle after seq zero
  assign lat_cnt_d = seq_zero ? LAT_CNT_W'(LAT_BASE) : lat_cnt_q + 1'b1;
  // ready is a flop, so it is set on the edge that opens the 1+N'th cycle
  wire lat_hit = (seq_zero || lat_run_q) && (lat_cnt_d == LAT_TOTAL);
  // hit wins over seq zero, else a zero setting would leave the window open
  assign lat_run_d = lat_hit ? 1'b0 : (seq_zero ? 1'b1 : lat_run_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_cnt_q <= CNT_RST;
      lat_run_q <= 1'b0;
      dir_ready_q <= 1'b0;
    end else begin
      lat_cnt_q <= lat_cnt_d;
      lat_run_q <= lat_run_d;
      dir_ready_q <= DIRECT_EN && lat_hit;
    end
  end
  assign dir_tx_ready = dir_ready_q;
  assign aux_seq_out = lat_run_q;

  // ----------------------------------------------------------------
  // control word registers
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] idx_d;
  logic [WORD_W-1:0] txcw_q;
  logic txcw_on_q;
  logic [IDX_W-1:0] reg_word;
  // byte mode drops the two lane bits before decode
  assign reg_word = IDX_W'(reg_addr >> ASHIFT);
  assign idx_d = idx_we ? idx_wr[IDX_W-1:0] : idx_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_q <= IDX_RST;
      txcw_q <= WORD_RST;
      txcw_on_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      if (txcw_we) begin
        txcw_q <= txcw_wr;
      end
      txcw_on_q <= CW_ACCESS_EN && txcw_en;
    end
  end
  wire at_index = (hf_pos == idx_q);
  // rx capture at the selected position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_cw_q <= WORD_RST;
    end else if (CW_ACCESS_EN && at_index) begin
      rx_cw_q <= rx_word;
    end
  end

  // ----------------------------------------------------------------
  // transmit control word arbitration
  // ----------------------------------------------------------------
  wire ovr_hit = txcw_on_q && at_index;
  // register override first, every other source after it
  wire [WORD_W-1:0] cw_sel = ovr_hit ? txcw_q : std_cw_data;
  wire cw_sel_v = ovr_hit || std_cw_valid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_cw_q <= WORD_RST;
      tx_cw_valid_q <= 1'b0;
    end else begin
      tx_cw_q <= cw_sel;
      tx_cw_valid_q <= cw_sel_v;
    end
  end

  // ----------------------------------------------------------------
  // data path through the fifo
  // ----------------------------------------------------------------
  wire aux_take = AUX_EN && aux_tx_valid;
  wire dir_take = dir_ready_q && dir_tx_valid;
  wire [WORD_W-1:0] in_word = aux_take ? aux_tx_data : dir_tx_data;
  logic f_in_ready, f_out_valid;
  logic [WORD_W-1:0] f_out_data;
  wire f_pop = f_out_valid && tx_ready;
  cw_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid((aux_take || dir_take) && f_in_ready),
    .in_ready(f_in_ready),
    .in_data(in_word),
    .out_valid(f_out_valid),
    .out_ready(tx_ready),
    .out_data(f_out_data)
  );
  // output stage; a full fifo drops user words, limitation of no backpressure on aux
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_word_q <= WORD_RST;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= f_pop;
      if (f_pop) begin
        tx_word_q <= f_out_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // window opens after seq zero whenever the total latency is above one
  sequence s_window_open;
    seq_zero && (LAT_TOTAL != LAT_CNT_W'(LAT_BASE));
  endsequence
  // a word leaves the fifo and shows toward the line one edge later
  sequence s_word_out;
    f_pop ##1 tx_valid_q;
  endsequence
  // a setting outside the range is a build mistake, flagged from the first edge
  chk_lat_range: assert property (@(posedge clk)
    (EXTRA_LAT >= 0) && (EXTRA_LAT <= LAT_MAX))
    else $error("extra write latency out of range");
  // ready is only legal exactly 1+N cycles after a zero position
  chk_ready_after_lat: assert property (@(posedge clk) disable iff (!rst_n)
    dir_tx_ready |-> $past(seq_zero, LAT_TOTAL))
    else $error("direct ready off its latency slot");
  chk_window_open: assert property (@(posedge clk) disable iff (!rst_n)
    s_window_open |=> aux_seq_out)
    else $error("latency window did not open");
  chk_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dir_tx_ready) |-> DIRECT_EN)
    else $error("ready without direct");
  chk_override_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ovr_hit |=> (tx_cw_q == $past(txcw_q)) && tx_cw_valid_q)
    else $error("override lost");
  chk_rx_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (CW_ACCESS_EN && at_index) |=> (rx_cw_q == $past(rx_word)))
    else $error("rx miss");
  chk_idx_write: assert property (@(posedge clk) disable iff (!rst_n)
    idx_we |=> (idx_q == $past(idx_wr[IDX_W-1:0])))
    else $error("index write lost");
  // with no word taken and none drained the fifo level must not move
  chk_aux_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (!(AUX_EN && aux_tx_valid) && !dir_take && !f_pop) |=> $stable(u_fifo.cnt_q))
    else $error("fifo moved with no word taken");
  chk_word_out: assert property (@(posedge clk) disable iff (!rst_n)
    s_word_out |-> (tx_word_q == $past(f_out_data)))
    else $error("fifo word lost on the way out");
  // the window never outlives the total latency
  chk_lat_bound: assert property (@(posedge clk) disable iff (!rst_n)
    !lat_run_q || (lat_cnt_q < LAT_TOTAL))
    else $error("latency count");
  chk_no_override_off: assert property (@(posedge clk) disable iff (!rst_n)
    !CW_ACCESS_EN |-> !ovr_hit)
    else $error("override while off");
  // word mode passes the address through untouched
  chk_addr_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ADDR_MODE == ADDR_WORD) |-> (reg_word == reg_addr[IDX_W-1:0]))
    else $error("word address altered");
endmodule

// >>> sim/user_side_model.sv
// user logic model feeding the aux and direct transmit ports
`timescale 1ns/10ps
module user_side_model
  import cw_access_pkg::*;
#(
  parameter int EXTRA_LAT = 0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing from the block
  input wire logic [SEQ_W-1:0] frame_seq,
  input wire logic dir_tx_ready,
  // writes toward the block
  output logic aux_tx_valid,
  output logic [WORD_W-1:0] aux_tx_data,
  output logic dir_tx_valid,
  output logic [WORD_W-1:0] dir_tx_data
);
  localparam logic [WORD_W-1:0] WORD_OK = 32'hC0DE_1234;
  int cnt = 0;
  bit armed = 0;
  // idle data is the inverse so a stale word cannot pass as fresh
  always @(negedge clk) begin
    aux_tx_valid <= rst_n && armed && cnt == EXTRA_LAT;
    aux_tx_data <= (armed && cnt == EXTRA_LAT) ? WORD_OK : ~WORD_OK;
    dir_tx_valid <= rst_n && dir_tx_ready;
    dir_tx_data <= dir_tx_ready ? WORD_OK : ~WORD_OK;
  end
  // count frame clock cycles from the zero sequence position
  always @(posedge clk) begin
    if (frame_seq == SEQ_FIRST) begin
      cnt <= 0;
      armed <= 1;
    end else if (cnt > EXTRA_LAT) begin
      armed <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> sim/cpri_aux_ctrl_word_access_test.sv
// self-checking bench for the control word access block
`timescale 1ns/10ps
module cpri_aux_ctrl_word_access_test;
  import cw_access_pkg::*;
  localparam int N = 2;
  logic clk = 0, rst_n = 0, idx_we = 0, txcw_we = 0, txcw_en = 0, std_cw_valid = 0;
  logic tx_ready = 1;
  logic [SEQ_W-1:0] frame_seq = 8'h05;
  logic [IDX_W-1:0] hf_pos = 8'h00;
  logic [IDX_W+1:0] reg_addr = 10'h000;
  logic [WORD_W-1:0] idx_wr = 32'h0, txcw_wr = 32'h0, std_cw_data = 32'h0, rx_word = 32'h0;
  logic aux_tx_valid, dir_tx_valid, aux_seq_out, dir_tx_ready, tx_cw_valid_q, tx_valid_q;
  logic [WORD_W-1:0] aux_tx_data, dir_tx_data, tx_cw_q, rx_cw_q, tx_word_q;
  logic [IDX_W-1:0] idx_q;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, k;
  always #2.5 clk = ~clk;
  cw_access #(.EXTRA_LAT(N), .AUX_EN(1'b1), .CW_ACCESS_EN(1'b1)) uut (.clk(clk), .rst_n(rst_n),
    .frame_seq(frame_seq), .hf_pos(hf_pos), .reg_addr(reg_addr), .idx_wr(idx_wr),
    .idx_we(idx_we), .txcw_wr(txcw_wr), .txcw_we(txcw_we), .txcw_en(txcw_en),
    .aux_tx_valid(aux_tx_valid), .aux_tx_data(aux_tx_data), .dir_tx_valid(dir_tx_valid),
    .dir_tx_data(dir_tx_data), .std_cw_valid(std_cw_valid), .std_cw_data(std_cw_data),
    .rx_word(rx_word), .tx_ready(tx_ready), .aux_seq_out(aux_seq_out),
    .dir_tx_ready(dir_tx_ready), .tx_cw_q(tx_cw_q), .tx_cw_valid_q(tx_cw_valid_q),
    .idx_q(idx_q), .rx_cw_q(rx_cw_q), .tx_word_q(tx_word_q), .tx_valid_q(tx_valid_q));
  user_side_model #(.EXTRA_LAT(N)) user (.clk(clk), .rst_n(rst_n), .frame_seq(frame_seq),
    .dir_tx_ready(dir_tx_ready), .aux_tx_valid(aux_tx_valid), .aux_tx_data(aux_tx_data),
    .dir_tx_valid(dir_tx_valid), .dir_tx_data(dir_tx_data));
  // -----------------------------------------------------------------
  // shared helpers
  // -----------------------------------------------------------------
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard: the whole run needs well under two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  // ready pulse lands 1+N cycles after the zero position, word reaches the line
  task automatic t_latency();
    frame_seq = SEQ_FIRST;
    @(posedge clk);
    @(negedge clk) frame_seq = 8'h01;
    check({31'h0, aux_seq_out}, 32'h1);
    k = 1;
    while (dir_tx_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check(32'(k), 32'(LAT_BASE + N));
    check({31'h0, aux_seq_out}, 32'h0);
    k = 0;
    while (tx_valid_q !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check({31'h0, tx_valid_q}, 32'h1);
    check(tx_word_q, 32'hC0DE_1234);
    $display("latency test done");
  endtask
  // register override wins over the standard source only at the chosen slot
  task automatic t_override();
    idx_wr = 32'h0000_00FF;
    idx_we = 1;
    txcw_wr = 32'h1357_9BDF;
    txcw_we = 1;
    std_cw_valid = 1;
    std_cw_data = 32'h2468_ACE0;
    @(negedge clk) idx_we = 0;
    txcw_we = 0;
    txcw_en = 1;
    hf_pos = IDX_LAST;
    rx_word = 32'h8421_0FED;
    repeat (3) @(negedge clk);
    check({24'h0, idx_q}, 32'h0000_00FF);
    check(tx_cw_q, 32'h1357_9BDF);
    check({31'h0, tx_cw_valid_q}, 32'h1);
    check(rx_cw_q, 32'h8421_0FED);
    hf_pos = 8'h10;
    rx_word = 32'h0;
    repeat (3) @(negedge clk);
    check(tx_cw_q, 32'h2468_ACE0);
    check(rx_cw_q, 32'h8421_0FED);
    txcw_en = 0;
    hf_pos = IDX_LAST;
    repeat (3) @(negedge clk);
    check(tx_cw_q, 32'h2468_ACE0);
    $display("override test done");
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_latency();
    t_latency();
    t_override();
    print_verdict();
  end
endmodule
